/* verilog/sfida_top.sv */
// Interrupt enables, interrupt status and data push/pop access for the serial FIFOs.
`default_nettype none
// Notes on behaviour
// - Enabled transmit error flag raises the interrupt; disabled it does not.
// - Enabled receive error flag raises the interrupt; disabled it does not.
// - Transmit level interrupt when fill falls to trigger, if both enables set.
// - Receive level interrupt when fill rises above trigger, if both enables set.
// - Ones written to enable-clear bits 3:0 clear enables; zeros do nothing.
// - Enable-set and enable-clear both read back the four enables.
// - Status shows pending AND enable per source plus peripheral interrupt bit 4.
// - Writing transmit data pushes bits 8:0 as one character.
// - Receive data read returns oldest character, masked to configured length.
// - Bit 13 of receive read flags a framing error for that character.
// - Bit 14 of receive read flags a parity error for that character.
// - Error flags are stored per entry with their character.
// - Bit 15 of receive read carries that character's noise flag.
// - Receive read pops the entry; peek register returns it without popping.
// - Transmit trigger 0 means empty; value n means drained to n entries.
// - Receive trigger 0 means one entry; value n means n+1 entries.
module sfida_top
    import sfida_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  rst_n,
    // Register port
    input  wire logic [ADDR_W-1:0]     reg_addr,
    input  wire logic                  reg_write,
    input  wire logic                  reg_read,
    input  wire logic [31:0]           reg_wdata,
    output logic      [31:0]           reg_rdata,
    output logic                       reg_rvalid,
    // Configuration and flags held elsewhere in the serial port
    input  wire logic                  tx_error,
    input  wire logic                  rx_error,
    input  wire logic                  tx_level_trigger_enable,
    input  wire logic                  rx_level_trigger_enable,
    input  wire logic [TRIG_W-1:0]     tx_level_trigger,
    input  wire logic [TRIG_W-1:0]     rx_level_trigger,
    input  wire logic [1:0]            char_length,
    input  wire logic [1:0]            parity_select,
    input  wire logic                  peripheral_irq,
    // Transmitter side
    output logic                       tx_valid,
    output logic      [CHAR_W-1:0]     tx_char,
    input  wire logic                  tx_ready,
    // Receiver side
    input  wire logic                  rx_valid,
    input  wire logic [CHAR_W-1:0]     rx_char,
    input  wire logic                  framing_error,
    input  wire logic                  parity_error,
    input  wire logic                  rx_noise_seen,
    output logic                       rx_ready,
    // Fill levels and interrupt
    output logic      [$clog2(DEPTH+1)-1:0] tx_fill,
    output logic      [$clog2(DEPTH+1)-1:0] rx_fill,
    output logic                       fifo_irq
);
    localparam int CNT_W = $clog2(DEPTH+1);

    // The trigger fields can only name levels up to the depth of the stores.
    if (DEPTH != (1 << TRIG_W)) begin : g_depth_check
        $error("sfida_top: DEPTH must match the trigger field range");
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Parity is checked by the receiver and never stored with the data,
    // so only the character length decides how many bits are valid.
    function automatic logic [CHAR_W-1:0] char_mask(input logic [1:0] len);
        logic [CHAR_W-1:0] m;
        m = 9'h01ff;
        if (len == CHAR_LEN_7) begin
            m = 9'h007f;
        end else if (len == CHAR_LEN_8) begin
            m = 9'h00ff;
        end
        return m;
    endfunction

    function automatic logic [31:0] rx_word(input logic [RX_ENTRY_W-1:0] e,
                                            input logic [1:0]            len);
        logic [31:0] w;
        w                  = '0;
        w[CHAR_W-1:0]      = e[CHAR_W-1:0] & char_mask(len);
        w[BIT_FRAMING_ERR] = e[CHAR_W];
        w[BIT_PARITY_ERR]  = e[CHAR_W+1];
        w[BIT_NOISE]       = e[CHAR_W+2];
        return w;
    endfunction

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    logic wr_set;
    logic wr_clr;
    logic wr_push;
    logic rd_pop;

    assign wr_set  = reg_write && (reg_addr == OFS_IRQ_EN_SET);
    assign wr_clr  = reg_write && (reg_addr == OFS_IRQ_EN_CLR);
    assign wr_push = reg_write && (reg_addr == OFS_TX_PUSH);
    assign rd_pop  = reg_read && (reg_addr == OFS_RX_POP);

    // ------------------------------------------------------------------
    // Interrupt enables
    // ------------------------------------------------------------------
    logic [NUM_IRQ_EN-1:0] irq_en_q;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            irq_en_q <= IRQ_EN_RESET;
        end else if (wr_set) begin
            irq_en_q <= irq_en_q | reg_wdata[NUM_IRQ_EN-1:0];
        end else if (wr_clr) begin
            irq_en_q <= irq_en_q & ~reg_wdata[NUM_IRQ_EN-1:0];
        end
    end

    // ------------------------------------------------------------------
    // Transmit FIFO
    // ------------------------------------------------------------------
    logic             tx_full;
    logic             tx_empty;
    logic [CNT_W-1:0] tx_count;

    sfida_fifo #(
        .WIDTH (CHAR_W),
        .DEPTH (DEPTH)
    ) u_tx_fifo (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .push      (wr_push),
        .push_data (reg_wdata[CHAR_W-1:0]),
        .pop       (tx_ready && !tx_empty),
        .head_data (tx_char),
        .count     (tx_count),
        .full      (tx_full),
        .empty     (tx_empty)
    );

    assign tx_valid = !tx_empty;
    assign tx_fill  = tx_count;

    // ------------------------------------------------------------------
    // Receive FIFO
    // ------------------------------------------------------------------
    logic                  rx_full;
    logic                  rx_empty;
    logic [CNT_W-1:0]      rx_count;
    logic [RX_ENTRY_W-1:0] rx_head;

    sfida_fifo #(
        .WIDTH (RX_ENTRY_W),
        .DEPTH (DEPTH)
    ) u_rx_fifo (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .push      (rx_valid),
        .push_data ({rx_noise_seen, parity_error, framing_error, rx_char}),
        .pop       (rd_pop),
        .head_data (rx_head),
        .count     (rx_count),
        .full      (rx_full),
        .empty     (rx_empty)
    );

    assign rx_ready = !rx_full;
    assign rx_fill  = rx_count;

    // ------------------------------------------------------------------
    // Pending sources and status
    // ------------------------------------------------------------------
    logic                  tx_lvl_hit;
    logic                  rx_lvl_hit;
    logic [NUM_IRQ_EN-1:0] pending;
    logic [4:0]            status;

    // Level sources are not latched: they follow the fill against the trigger every cycle,
    // so a trigger hit that ends before software looks leaves no trace.
    assign tx_lvl_hit = tx_level_trigger_enable &&
                        (tx_count <= CNT_W'(tx_level_trigger));
    assign rx_lvl_hit = rx_level_trigger_enable &&
                        (rx_count > CNT_W'(rx_level_trigger));

    always_comb begin
        pending               = '0;
        pending[BIT_TX_ERROR] = tx_error;
        pending[BIT_RX_ERROR] = rx_error;
        pending[BIT_TX_LEVEL] = tx_lvl_hit;
        pending[BIT_RX_LEVEL] = rx_lvl_hit;
    end

    assign status   = {peripheral_irq, pending & irq_en_q};
    assign fifo_irq = |status;

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            reg_rdata  <= '0;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_read;
            if (reg_read) begin
                case (reg_addr)
                    OFS_IRQ_EN_SET,
                    OFS_IRQ_EN_CLR: reg_rdata <= {28'h000_0000, irq_en_q};
                    OFS_IRQ_STATUS: reg_rdata <= {27'h000_0000, status};
                    OFS_RX_POP,
                    OFS_RX_PEEK:    reg_rdata <= rx_empty ? 32'h0000_0000 :
                                                 rx_word(rx_head, char_length);
                    default:        reg_rdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Parity selection only shapes the receiver; it is accepted here so the
    // port set matches the configuration that governs the stored width.
    logic unused_ok;
    assign unused_ok = ^{parity_select, tx_full};
endmodule : sfida_top
`default_nettype wire

/* verilog/sfida_pkg.sv */
// Shared constants for the serial FIFO interrupt and data access block.
`default_nettype none
package sfida_pkg;
    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int          ADDR_W          = 12;
    localparam logic [11:0] OFS_IRQ_EN_SET  = 12'h0e10;
    localparam logic [11:0] OFS_IRQ_EN_CLR  = 12'h0e14;
    localparam logic [11:0] OFS_IRQ_STATUS  = 12'h0e18;
    localparam logic [11:0] OFS_TX_PUSH     = 12'h0e20;
    localparam logic [11:0] OFS_RX_POP      = 12'h0e30;
    localparam logic [11:0] OFS_RX_PEEK     = 12'h0e40;

    // ------------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------------
    localparam int          BIT_TX_ERROR    = 0;
    localparam int          BIT_RX_ERROR    = 1;
    localparam int          BIT_TX_LEVEL    = 2;
    localparam int          BIT_RX_LEVEL    = 3;
    localparam int          BIT_PERIPH_IRQ  = 4;
    localparam int          NUM_IRQ_EN      = 4;
    localparam int          CHAR_W          = 9;
    localparam int          BIT_FRAMING_ERR = 13;
    localparam int          BIT_PARITY_ERR  = 14;
    localparam int          BIT_NOISE       = 15;
    localparam int          RX_ENTRY_W      = CHAR_W + 3;
    localparam int          TRIG_W          = 4;

    // ------------------------------------------------------------------
    // Reset values and encodings
    // ------------------------------------------------------------------
    localparam logic [3:0]  IRQ_EN_RESET    = 4'h0;
    localparam int          FIFO_DEPTH      = 16;
    localparam logic [1:0]  CHAR_LEN_7      = 2'h0;
    localparam logic [1:0]  CHAR_LEN_8      = 2'h1;
endpackage : sfida_pkg
`default_nettype wire

/* verilog/sfida_fifo.sv */
// Synchronous first-in first-out store with fill count and head view.
`default_nettype none
module sfida_fifo
    import sfida_pkg::*;
#(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic                       sys_clk,
    input  wire logic                       rst_n,
    // Fill side
    input  wire logic                       push,
    input  wire logic [WIDTH-1:0]           push_data,
    // Drain side
    input  wire logic                       pop,
    output logic      [WIDTH-1:0]           head_data,
    // State
    output logic      [$clog2(DEPTH+1)-1:0] count,
    output logic                            full,
    output logic                            empty
);
    localparam int PTR_W = $clog2(DEPTH);
    localparam int CNT_W = $clog2(DEPTH+1);

    // The pointers wrap by overflow, so only powers of two are served.
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_check
        $error("sfida_fifo: DEPTH must be a power of two of at least 2");
    end

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PTR_W-1:0] wr_ptr_q;
    logic [PTR_W-1:0] rd_ptr_q;
    logic [CNT_W-1:0] count_q;
    logic             do_push;
    logic             do_pop;

    assign full      = (count_q == CNT_W'(DEPTH));
    assign empty     = (count_q == '0);
    assign count     = count_q;
    assign head_data = mem_q[rd_ptr_q];
    // Pushing into a full store or popping an empty one is ignored.
    assign do_push   = push && !full;
    assign do_pop    = pop && !empty;

    always_ff @(posedge sys_clk) begin
        if (do_push) begin
            mem_q[wr_ptr_q] <= push_data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end else begin
            if (do_push) begin
                wr_ptr_q <= wr_ptr_q + PTR_W'(1);
            end
            if (do_pop) begin
                rd_ptr_q <= rd_ptr_q + PTR_W'(1);
            end
            if (do_push && !do_pop) begin
                count_q <= count_q + CNT_W'(1);
            end else if (do_pop && !do_push) begin
                count_q <= count_q - CNT_W'(1);
            end
        end
    end
endmodule : sfida_fifo
`default_nettype wire

/* verif/sfida_top_props.sv */
// Port-level assertions for the serial FIFO interrupt and data access block.
`default_nettype none
module sfida_top_props
    import sfida_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    // Clock and reset
    input wire logic                       sys_clk,
    input wire logic                       rst_n,
    // Register port
    input wire logic [ADDR_W-1:0]          reg_addr,
    input wire logic                       reg_write,
    input wire logic                       reg_read,
    input wire logic [31:0]                reg_rdata,
    input wire logic                       reg_rvalid,
    // Flags and interrupt
    input wire logic                       tx_error,
    input wire logic                       rx_error,
    input wire logic                       tx_level_trigger_enable,
    input wire logic                       rx_level_trigger_enable,
    input wire logic                       peripheral_irq,
    input wire logic                       fifo_irq,
    // Data sides
    input wire logic                       tx_valid,
    input wire logic                       tx_ready,
    input wire logic                       rx_valid,
    input wire logic                       rx_ready,
    input wire logic [$clog2(DEPTH+1)-1:0] tx_fill,
    input wire logic [$clog2(DEPTH+1)-1:0] rx_fill
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    logic rx_pop_now;
    logic tx_push_now;
    assign rx_pop_now  = reg_read && reg_addr == OFS_RX_POP && rx_fill != '0;
    assign tx_push_now = reg_write && reg_addr == OFS_TX_PUSH && tx_fill < DEPTH;

    sequence s_tx_push;
        tx_push_now && !(tx_valid && tx_ready);
    endsequence
    sequence s_tx_take;
        tx_valid && tx_ready && !tx_push_now;
    endsequence
    sequence s_rx_take;
        rx_valid && rx_ready && !rx_pop_now;
    endsequence

    a_read_answer: assert property (reg_read |=> reg_rvalid) else $error("read not answered");
    a_rvalid_idle: assert property (!reg_read |=> !reg_rvalid) else $error("stray read answer");
    a_rdata_holds: assert property (!reg_read |=> $stable(reg_rdata)) else $error("read data moved");
    a_push_counts: assert property (s_tx_push |=> tx_fill == $past(tx_fill) + 1'b1)
        else $error("transmit push not counted");
    a_drain_counts: assert property (s_tx_take |=> tx_fill == $past(tx_fill) - 1'b1)
        else $error("transmit drain not counted");
    a_rx_counts: assert property (s_rx_take |=> rx_fill == $past(rx_fill) + 1'b1)
        else $error("receive entry not counted");
    a_tx_valid_fill: assert property (tx_valid == (tx_fill != '0)) else $error("tx_valid vs fill");
    a_rx_ready_fill: assert property (rx_ready == (rx_fill != DEPTH)) else $error("rx_ready vs fill");
    a_empty_pop_zero: assert property (reg_read && reg_addr == OFS_RX_POP && rx_fill == '0
        |=> reg_rvalid && reg_rdata == 32'h0000_0000 && rx_fill == '0) else $error("empty pop not zero");
    a_irq_periph: assert property (peripheral_irq |-> fifo_irq) else $error("peripheral irq lost");
    a_irq_quiet: assert property (!peripheral_irq && !tx_error && !rx_error
        && !tx_level_trigger_enable && !rx_level_trigger_enable |-> !fifo_irq) else $error("irq without cause");
endmodule // sfida_top_props
`default_nettype wire

/* verif/sfida_tb_top.sv */
// Self-checking testbench for the serial FIFO interrupt and data access block.
`default_nettype none
module sfida_tb_top
    import sfida_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int DEPTH = 16;
    logic sys_clk, rst_n, reg_write, reg_read, reg_rvalid, tx_error, rx_error, peripheral_irq;
    logic tx_level_trigger_enable, rx_level_trigger_enable, tx_valid, tx_ready, rx_valid, rx_ready;
    logic framing_error, parity_error, rx_noise_seen, fifo_irq;
    logic [ADDR_W-1:0] reg_addr;
    logic [31:0]       reg_wdata, reg_rdata;
    logic [TRIG_W-1:0] tx_level_trigger, rx_level_trigger;
    logic [1:0]        char_length;
    logic [CHAR_W-1:0] tx_char, rx_char;
    logic [$clog2(DEPTH+1)-1:0] tx_fill, rx_fill;
    int fails = 0;
    int cmp_count = 0;

    sfida_top #(.DEPTH(DEPTH)) dut (.sys_clk, .rst_n, .reg_addr, .reg_write, .reg_read, .reg_wdata,
        .reg_rdata, .reg_rvalid, .tx_error, .rx_error, .tx_level_trigger_enable, .rx_level_trigger_enable,
        .tx_level_trigger, .rx_level_trigger, .char_length, .parity_select(2'h0), .peripheral_irq,
        .tx_valid, .tx_char, .tx_ready, .rx_valid, .rx_char, .framing_error, .parity_error, .rx_noise_seen,
        .rx_ready, .tx_fill, .rx_fill, .fifo_irq);

    always #20 sys_clk = ~sys_clk;

    // --------------------------------------------------------------
    // Access tasks
    // --------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(negedge sys_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_write = 1'b1;
        @(negedge sys_clk);
        reg_write = 1'b0;
    endtask
    task automatic rchk(input string what, input logic [11:0] a, input logic [31:0] exp);
        @(negedge sys_clk);
        reg_addr = a;
        reg_read = 1'b1;
        @(negedge sys_clk);
        reg_read = 1'b0;
        check("rvalid", 32'(reg_rvalid), 32'h1);
        check(what, reg_rdata, exp);
    endtask
    task automatic rx_put(input logic [8:0] c, input logic fe, input logic pe, input logic nz);
        @(negedge sys_clk);
        {rx_char, framing_error, parity_error, rx_noise_seen, rx_valid} = {c, fe, pe, nz, 1'b1};
        @(negedge sys_clk);
        rx_valid = 1'b0;
    endtask
    task automatic tx_take();
        @(negedge sys_clk);
        tx_ready = 1'b1;
        @(negedge sys_clk);
        tx_ready = 1'b0;
    endtask
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // --------------------------------------------------------------
    // Tests
    // --------------------------------------------------------------
    initial begin
        {sys_clk, rst_n, reg_write, reg_read, tx_error, rx_error, peripheral_irq, tx_ready, rx_valid} = '0;
        {tx_level_trigger_enable, rx_level_trigger_enable, framing_error, parity_error, rx_noise_seen} = '0;
        {reg_addr, reg_wdata, tx_level_trigger, rx_level_trigger, rx_char} = '0;
        char_length = CHAR_LEN_8;
        repeat (12) @(posedge sys_clk);
        @(negedge sys_clk);
        rst_n = 1'b1;
        rchk("enable_set", OFS_IRQ_EN_SET, 32'h0000_0000);
        rchk("enable_clear", OFS_IRQ_EN_CLR, 32'h0000_0000);
        rchk("unmapped", 12'h0e1c, 32'h0000_0000);
        tx_level_trigger_enable = 1'b1;
        rx_level_trigger_enable = 1'b1;
        tx_error = 1'b1;
        rchk("status", OFS_IRQ_STATUS, 32'h0000_0000);
        check("irq", 32'(fifo_irq), 32'h0);
        wr(OFS_IRQ_EN_SET, 32'h0000_0001);
        rchk("status", OFS_IRQ_STATUS, 32'h0000_0001);
        check("irq", 32'(fifo_irq), 32'h1);
        wr(OFS_IRQ_EN_SET, 32'h0000_000e);
        rchk("enable_set", OFS_IRQ_EN_SET, 32'h0000_000f);
        rchk("enable_clear", OFS_IRQ_EN_CLR, 32'h0000_000f);
        rchk("status", OFS_IRQ_STATUS, 32'h0000_0005);
        rx_error = 1'b1;
        peripheral_irq = 1'b1;
        rchk("status", OFS_IRQ_STATUS, 32'h0000_0017);
        wr(OFS_IRQ_EN_CLR, 32'h0000_0003);
        rchk("enable_clear", OFS_IRQ_EN_CLR, 32'h0000_000c);
        rchk("status", OFS_IRQ_STATUS, 32'h0000_0014);
        wr(OFS_IRQ_EN_CLR, 32'h0000_000c);
        {tx_error, rx_error, peripheral_irq} = '0;
        rchk("status", OFS_IRQ_STATUS, 32'h0000_0000);
        // Transmit path with a trigger of one entry.
        tx_level_trigger = 4'h1;
        wr(OFS_IRQ_EN_SET, 32'h0000_0004);
        wr(OFS_TX_PUSH, 32'h0000_01a5);
        wr(OFS_TX_PUSH, 32'h0000_00ff);
        check("tx_fill", 32'(tx_fill), 32'h2);
        check("tx_char", 32'(tx_char), 32'h0000_01a5);
        rchk("status", OFS_IRQ_STATUS, 32'h0000_0000);
        rchk("push_read", OFS_TX_PUSH, 32'h0000_0000);
        tx_take();
        check("tx_char", 32'(tx_char), 32'h0000_00ff);
        rchk("status", OFS_IRQ_STATUS, 32'h0000_0004);
        tx_take();
        check("tx_valid", 32'(tx_valid), 32'h0);
        wr(OFS_IRQ_EN_CLR, 32'h0000_0004);
        // Receive path with a trigger of two entries.
        rx_level_trigger = 4'h1;
        wr(OFS_IRQ_EN_SET, 32'h0000_0008);
        rx_put(9'h1c3, 1'b1, 1'b0, 1'b0);
        rchk("status", OFS_IRQ_STATUS, 32'h0000_0000);
        rx_put(9'h0d5, 1'b0, 1'b1, 1'b1);
        rchk("status", OFS_IRQ_STATUS, 32'h0000_0008);
        rchk("peek", OFS_RX_PEEK, 32'h0000_20c3);
        check("rx_fill", 32'(rx_fill), 32'h2);
        char_length = 2'h2;
        rchk("pop", OFS_RX_POP, 32'h0000_21c3);
        char_length = CHAR_LEN_7;
        rchk("pop", OFS_RX_POP, 32'h0000_c055);
        rchk("pop_empty", OFS_RX_POP, 32'h0000_0000);
        check("rx_fill", 32'(rx_fill), 32'h0);
        {tx_level_trigger_enable, rx_level_trigger_enable} = '0;
        @(negedge sys_clk);
        check("irq", 32'(fifo_irq), 32'h0);
        // Receive store filled to the top, an extra entry dropped, then a reset in mid-run.
        rx_level_trigger = 4'hf;
        rx_level_trigger_enable = 1'b1;
        for (int i = 0; i < 15; i++) begin
            rx_put(9'(i + 1), 1'b0, 1'b0, 1'b0);
        end
        rchk("status", OFS_IRQ_STATUS, 32'h0000_0000);
        rx_put(9'h0aa, 1'b0, 1'b0, 1'b0);
        rchk("status", OFS_IRQ_STATUS, 32'h0000_0008);
        check("irq", 32'(fifo_irq), 32'h1);
        check("rx_ready", 32'(rx_ready), 32'h0);
        rx_put(9'h155, 1'b0, 1'b0, 1'b0);
        check("rx_fill", 32'(rx_fill), 32'h10);
        rchk("peek", OFS_RX_PEEK, 32'h0000_0001);
        check("rx_fill", 32'(rx_fill), 32'h10);
        rst_n = 1'b0;
        repeat (2) @(negedge sys_clk);
        rst_n = 1'b1;
        check("rx_fill", 32'(rx_fill), 32'h0);
        check("rx_ready", 32'(rx_ready), 32'h1);
        rchk("enable_set", OFS_IRQ_EN_SET, 32'h0000_0000);
        rchk("pop_empty", OFS_RX_POP, 32'h0000_0000);
        end_sim();
    end

    initial begin
        repeat (3000) @(posedge sys_clk);
        fails++;
        end_sim();
    end
endmodule // sfida_tb_top

bind sfida_top sfida_top_props #(.DEPTH(DEPTH)) u_props (.sys_clk, .rst_n, .reg_addr, .reg_write, .reg_read,
    .reg_rdata, .reg_rvalid, .tx_error, .rx_error, .tx_level_trigger_enable, .rx_level_trigger_enable,
    .peripheral_irq, .fifo_irq, .tx_valid, .tx_ready, .rx_valid, .rx_ready, .tx_fill, .rx_fill);
`default_nettype wire
